// >>> rtl/sfr_pkg.sv
// Constants, field layout and types of the SIMD floating-point state registers.
// Function
// - Eight separate 128-bit data registers, not aliased to any other storage.
// - In 64-bit mode registers 8 to 15 are reachable via the extension prefix.
// - A meaningless extension prefix is ignored; the instruction runs normally.
// - Scalar operations read and write only the low 32-bit doubleword.
// - Data registers load and store in 32, 64 or 128-bit transfers.
// - A full store emits 16 bytes, lowest register byte at lowest address.
// - Control/status is loaded by load/restore and stored by store/save instructions.
// - Bits 16 to 31 read zero; nonzero write by load/restore faults.
// - Bits 0 to 5 are sticky flags cleared only by writing zero.
// - Bits 7 to 12 are masks; set masks, clear unmasks.
// - Reset sets all six mask bits.
// - Unmasking a set flag by a load raises no exception then.
// - Bits 13 and 14 select the rounding of every result.
// - Flush enabled with underflow masked: signed zero, inexact and underflow flags set.
// - With underflow unmasked the flush enable is disregarded.
// - The flush enable clears on reset.
// - Denormal-zero mode turns denormal sources into signed zeros first.
// - In denormal-zero mode the denormal flag and exception never occur.
// - The denormal-zero enable clears on reset.
// - Without denormal-zero support, writing bit 6 as one faults.
// - Data register contents are never used as a memory address.
package sfr_pkg;
	localparam int unsigned DATA_W = 128;
	localparam int unsigned CSR_W = 32;
	localparam int unsigned NUM_EXC = 6;
	localparam int unsigned FLAG_LSB = 0;
	localparam int unsigned DAZ_BIT = 6;
	localparam int unsigned MASK_LSB = 7;
	localparam int unsigned RND_LSB = 13;
	localparam int unsigned FLUSH_BIT = 15;
	localparam int unsigned RSVD_LSB = 16;
	localparam int unsigned EXC_INVALID = 0;
	localparam int unsigned EXC_DENORMAL = 1;
	localparam int unsigned EXC_ZERODIV = 2;
	localparam int unsigned EXC_OVERFLOW = 3;
	localparam int unsigned EXC_UNDERFLOW = 4;
	localparam int unsigned EXC_INEXACT = 5;
	localparam logic [31:0] CSR_RESET = 32'h0000_1F80;
	localparam logic [31:0] RSVD_MASK = 32'hFFFF_0000;
	localparam logic [31:0] DAZ_MASK = 32'h0000_0040;
	typedef enum logic [1:0] {
		SFR_RND_NEAREST = 2'b00,
		SFR_RND_DOWN = 2'b01,
		SFR_RND_UP = 2'b10,
		SFR_RND_ZERO = 2'b11
	} sfr_round_t;
	typedef enum logic [1:0] {
		SFR_SZ_32 = 2'b00,
		SFR_SZ_64 = 2'b01,
		SFR_SZ_128 = 2'b10
	} sfr_size_t;
endpackage

// >>> rtl/sfr_regs.sv
// SIMD floating-point data register bank and control/status register.
`timescale 1ns/1ps
module sfr_regs #(
	parameter int unsigned NUM_REGS = 16,
	parameter bit DAZ_SUPPORTED = 1'b1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic long_mode,
	input wire logic rd_a_prefix_ext,
	input wire logic [2:0] rd_a_sel,
	output logic [127:0] rd_a_data,
	input wire logic rd_b_prefix_ext,
	input wire logic [2:0] rd_b_sel,
	output logic [127:0] rd_b_data,
	input wire logic wr_en,
	input wire logic wr_prefix_ext,
	input wire logic [2:0] wr_sel,
	input wire sfr_pkg::sfr_size_t wr_size,
	input wire logic wr_scalar,
	input wire logic [127:0] wr_data,
	input wire logic st_en,
	input wire logic st_prefix_ext,
	input wire logic [2:0] st_sel,
	input wire sfr_pkg::sfr_size_t st_size,
	output logic st_valid,
	output logic [7:0] st_bytes [16],
	output logic [15:0] st_byte_en,
	input wire logic csr_load,
	input wire logic [31:0] csr_load_data,
	input wire logic csr_store,
	output logic [31:0] csr_store_data,
	output logic general_protection_fault,
	input wire logic exc_valid,
	input wire logic [5:0] exc_detected,
	input wire logic exc_underflow_det,
	output logic [5:0] exc_flags,
	output logic [5:0] exc_masks,
	output sfr_pkg::sfr_round_t rounding_select,
	output logic flush_underflow_enable,
	output logic flush_active,
	output logic denormal_input_zero_enable,
	output logic exc_raise
);
	// The index decode only knows a plain bank and an extended bank.
	if (NUM_REGS != 8 && NUM_REGS != 16) begin : gen_bad_num_regs
		$error("NUM_REGS must be 8 or 16");
	end

	// ---------------------------------------------------------------
	// Register index decode
	// ---------------------------------------------------------------
	// The extension bit only counts in 64-bit mode on a 16-entry bank;
	// elsewhere it is dropped so the instruction runs on regs 0 to 7.
	function automatic logic [3:0] reg_index(input logic ext, input logic [2:0] sel, input logic lm);
		reg_index = {ext && lm && (NUM_REGS == 16), sel};
	endfunction

	logic [127:0] data_q [NUM_REGS];
	logic [127:0] data_d [NUM_REGS];
	logic [3:0] wr_idx;
	logic [3:0] rd_a_idx;
	logic [3:0] rd_b_idx;
	logic [3:0] st_idx;
	logic [127:0] wr_keep;

	always_comb begin
		wr_idx = reg_index(wr_prefix_ext, wr_sel, long_mode);
		rd_a_idx = reg_index(rd_a_prefix_ext, rd_a_sel, long_mode);
		rd_b_idx = reg_index(rd_b_prefix_ext, rd_b_sel, long_mode);
		st_idx = reg_index(st_prefix_ext, st_sel, long_mode);
		// Scalar results touch only the low doubleword; loads honour size.
		if (wr_scalar || wr_size == sfr_pkg::SFR_SZ_32) begin
			wr_keep = 128'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF_0000_0000;
		end else if (wr_size == sfr_pkg::SFR_SZ_64) begin
			wr_keep = 128'hFFFF_FFFF_FFFF_FFFF_0000_0000_0000_0000;
		end else begin
			wr_keep = 128'h0;
		end
	end

	// ---------------------------------------------------------------
	// Data register bank
	// ---------------------------------------------------------------
	// Private storage with no path to any other register file or to address
	// generation; contents only leave as operands or store data.
	genvar g;
	generate
		for (g = 0; g < NUM_REGS; g++) begin : gen_reg
			always_comb begin
				data_d[g] = data_q[g];
				if (wr_en && wr_idx == 4'(g)) begin
					data_d[g] = (data_q[g] & wr_keep) | (wr_data & ~wr_keep);
				end
			end
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					data_q[g] <= 128'h0;
				end else begin
					data_q[g] <= data_d[g];
				end
			end
		end
	endgenerate

	assign rd_a_data = data_q[rd_a_idx[$clog2(NUM_REGS)-1:0]];
	assign rd_b_data = data_q[rd_b_idx[$clog2(NUM_REGS)-1:0]];

	// ---------------------------------------------------------------
	// Store path
	// ---------------------------------------------------------------
	logic st_valid_d;
	logic [7:0] st_bytes_d [16];
	logic [15:0] st_be_d;

	always_comb begin
		st_valid_d = st_en;
		st_be_d = 16'h0;
		for (int i = 0; i < 16; i++) begin
			// Byte i goes to the i-th address, lowest register byte first.
			st_bytes_d[i] = data_q[st_idx[$clog2(NUM_REGS)-1:0]][8*i +: 8];
		end
		if (st_en) begin
			unique case (st_size)
				sfr_pkg::SFR_SZ_32: st_be_d = 16'h000F;
				sfr_pkg::SFR_SZ_64: st_be_d = 16'h00FF;
				default: st_be_d = 16'hFFFF;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_valid <= 1'b0;
			st_byte_en <= 16'h0;
			for (int i = 0; i < 16; i++) begin
				st_bytes[i] <= 8'h00;
			end
		end else begin
			st_valid <= st_valid_d;
			st_byte_en <= st_be_d;
			st_bytes <= st_bytes_d;
		end
	end

	// ---------------------------------------------------------------
	// Control/status register
	// ---------------------------------------------------------------
	logic [31:0] csr_q;
	logic [31:0] csr_d;
	logic [31:0] csr_store_d;
	logic gp_d;
	logic raise_d;
	logic load_bad;
	logic [5:0] det_eff;
	logic [5:0] unmasked_hit;

	always_comb begin
		load_bad = |(csr_load_data & sfr_pkg::RSVD_MASK);
		if (!DAZ_SUPPORTED && (csr_load_data & sfr_pkg::DAZ_MASK) != 32'h0) begin
			load_bad = 1'b1;
		end
		det_eff = exc_detected;
		if (csr_q[sfr_pkg::DAZ_BIT]) begin
			det_eff[sfr_pkg::EXC_DENORMAL] = 1'b0;
		end
		if (flush_active && exc_underflow_det) begin
			det_eff[sfr_pkg::EXC_UNDERFLOW] = 1'b1;
			det_eff[sfr_pkg::EXC_INEXACT] = 1'b1;
		end
		unmasked_hit = det_eff & ~csr_q[sfr_pkg::MASK_LSB +: sfr_pkg::NUM_EXC];
		csr_d = csr_q;
		if (csr_load && !load_bad) begin
			csr_d = csr_load_data;
		end
		// A detection in the same cycle as a load wins over the clearing write.
		if (exc_valid) begin
			csr_d[sfr_pkg::FLAG_LSB +: sfr_pkg::NUM_EXC] = csr_d[sfr_pkg::FLAG_LSB +: sfr_pkg::NUM_EXC] | det_eff;
		end
		// Only a new detection raises; a load alone never does.
		raise_d = exc_valid && (|unmasked_hit);
		gp_d = csr_load && load_bad;
		csr_store_d = csr_store ? (csr_q & ~sfr_pkg::RSVD_MASK) : csr_store_data;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			csr_q <= sfr_pkg::CSR_RESET;
			csr_store_data <= 32'h0;
			general_protection_fault <= 1'b0;
			exc_raise <= 1'b0;
		end else begin
			csr_q <= csr_d;
			csr_store_data <= csr_store_d;
			general_protection_fault <= gp_d;
			exc_raise <= raise_d;
		end
	end

	assign exc_flags = csr_q[sfr_pkg::FLAG_LSB +: sfr_pkg::NUM_EXC];
	assign exc_masks = csr_q[sfr_pkg::MASK_LSB +: sfr_pkg::NUM_EXC];
	assign rounding_select = sfr_pkg::sfr_round_t'(csr_q[sfr_pkg::RND_LSB +: 2]);
	assign flush_underflow_enable = csr_q[sfr_pkg::FLUSH_BIT];
	// Unmasked underflow ignores the flush enable entirely.
	assign flush_active = csr_q[sfr_pkg::FLUSH_BIT] && csr_q[sfr_pkg::MASK_LSB + sfr_pkg::EXC_UNDERFLOW];
	assign denormal_input_zero_enable = csr_q[sfr_pkg::DAZ_BIT];

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (rst) csr_q[31:16] == 16'h0)
		else $error("reserved control bits nonzero");
	a_bad_load_fault: assert property (@(posedge clk_sys) disable iff (rst)
		csr_load && |csr_load_data[31:16] |=> general_protection_fault && $stable(csr_q[31:16]))
		else $error("reserved write did not fault");
	a_flag_sticky: assert property (@(posedge clk_sys) disable iff (rst)
		!$past(csr_load) && $past(exc_flags) != 6'h0 |-> (exc_flags & $past(exc_flags)) == $past(exc_flags))
		else $error("sticky flag dropped");
	a_reset_masks: assert property (@(posedge clk_sys) $past(rst) |-> exc_masks == 6'h3F && rounding_select == 2'b00
		&& !flush_underflow_enable && !denormal_input_zero_enable)
		else $error("bad control reset value");
	a_load_no_raise: assert property (@(posedge clk_sys) disable iff (rst) !exc_valid |=> !exc_raise)
		else $error("exception raised without detection");
	a_flush_flags: assert property (@(posedge clk_sys) disable iff (rst)
		exc_valid && flush_active && exc_underflow_det |=> exc_flags[4] && exc_flags[5])
		else $error("flush did not set flags");
	a_daz_no_flag: assert property (@(posedge clk_sys) disable iff (rst)
		denormal_input_zero_enable && !exc_flags[1] && !csr_load |=> !exc_flags[1])
		else $error("denormal flag set in zero mode");
	a_scalar_high: assert property (@(posedge clk_sys) disable iff (rst)
		wr_en && wr_scalar && rd_a_idx == wr_idx ##1 rd_a_idx == $past(wr_idx)
		|-> rd_a_data[127:32] == $past(rd_a_data[127:32]))
		else $error("scalar write touched upper lanes");
	a_store_order: assert property (@(posedge clk_sys) disable iff (rst)
		st_en && st_size == sfr_pkg::SFR_SZ_128 |=> st_valid && st_byte_en == 16'hFFFF
		&& st_bytes[0] == $past(data_q[st_idx[$clog2(NUM_REGS)-1:0]][7:0]))
		else $error("store byte order wrong");
endmodule

// >>> sim/sfr_pipe_model.sv
// Stand-in for the execution pipeline that reports detected floating-point conditions.
`timescale 1ns/1ps
module sfr_pipe_model (
	input wire logic clk_sys,
	input wire logic go,
	input wire logic [5:0] det,
	input wire logic unf,
	output logic exc_valid,
	output logic [5:0] exc_detected,
	output logic exc_underflow_det
);
	// Between reports the condition lines carry the inverted values, so a block that ignores the strobe is caught.
	always @(posedge clk_sys) begin
		exc_valid <= go;
		exc_detected <= go ? det : ~det;
		exc_underflow_det <= go ? unf : ~unf;
	end
endmodule

// >>> sim/test_simd_fp_state_registers.sv
// Self-checking bench for the SIMD floating-point state registers.
`timescale 1ns/1ps
module test_simd_fp_state_registers;
	localparam sfr_pkg::sfr_size_t S128 = sfr_pkg::SFR_SZ_128;
	logic clk_sys = 1'b0, rst = 1'b1;
	logic long_mode, rd_a_prefix_ext, rd_b_prefix_ext, wr_en, wr_prefix_ext, wr_scalar, st_en, st_prefix_ext;
	logic csr_load, csr_store, go, unf, st_valid, general_protection_fault, exc_valid, exc_raise, exc_underflow_det;
	logic flush_underflow_enable, flush_active, denormal_input_zero_enable;
	logic [2:0] rd_a_sel = 3'h3, rd_b_sel = 3'h3, wr_sel = 3'h3, st_sel = 3'h3;
	sfr_pkg::sfr_size_t wr_size = S128, st_size = S128;
	sfr_pkg::sfr_round_t rounding_select;
	logic [127:0] wr_data, rd_a_data, rd_b_data, cur;
	logic [31:0] csr_load_data, csr_store_data;
	logic [5:0] det, exc_detected, exc_flags, exc_masks;
	logic [15:0] st_byte_en;
	logic [7:0] st_bytes [16];
	int fail_count = 0, comparisons = 0;
	sfr_regs #(.NUM_REGS(16), .DAZ_SUPPORTED(1'b1)) i_sfr_regs (.clk_sys, .rst, .long_mode, .rd_a_prefix_ext,
		.rd_a_sel, .rd_a_data, .rd_b_prefix_ext, .rd_b_sel, .rd_b_data, .wr_en, .wr_prefix_ext, .wr_sel, .wr_size,
		.wr_scalar, .wr_data, .st_en, .st_prefix_ext, .st_sel, .st_size, .st_valid, .st_bytes, .st_byte_en,
		.csr_load, .csr_load_data, .csr_store, .csr_store_data, .general_protection_fault, .exc_valid, .exc_raise,
		.exc_detected, .exc_underflow_det, .exc_flags, .exc_masks, .rounding_select, .flush_underflow_enable,
		.flush_active, .denormal_input_zero_enable);
	sfr_pipe_model i_sfr_pipe_model (.clk_sys, .go, .det, .unf, .exc_valid, .exc_detected, .exc_underflow_det);
	initial forever #2.5 clk_sys = ~clk_sys;
	task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic req(input logic [4:0] s, input logic p, input sfr_pkg::sfr_size_t z, input logic c, input logic [127:0] d);
		@(posedge clk_sys);
		{wr_en, st_en, csr_load, csr_store, go} <= s;
		{wr_prefix_ext, rd_a_prefix_ext, wr_scalar} <= {p, p, c};
		wr_size <= z;
		st_size <= z;
		wr_data <= d;
		csr_load_data <= d[31:0];
		{unf, det} <= d[6:0];
		@(posedge clk_sys);
		{wr_en, st_en, csr_load, csr_store, go} <= 5'h00;
		#1;
	endtask
	task automatic ld(input logic [31:0] v);
		req(5'h04, 1'b0, S128, 1'b0, {96'h0, v});
	endtask
	task automatic rep(input logic [6:0] u);
		req(5'h01, 1'b0, S128, 1'b0, {121'h0, u});
		@(posedge clk_sys);
		#1;
	endtask
	task automatic t_data();
		cur = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;
		req(5'h10, 1'b0, S128, 1'b0, cur);
		chk("rd_a", cur, rd_a_data);
		req(5'h10, 1'b0, sfr_pkg::SFR_SZ_64, 1'b0, ~cur);
		cur[63:0] = ~cur[63:0];
		req(5'h10, 1'b0, S128, 1'b1, ~cur);
		cur[31:0] = ~cur[31:0];
		chk("rd_a", cur, rd_a_data);
		req(5'h08, 1'b0, S128, 1'b0, 128'h0);
		chk("st_valid", 1'b1, st_valid);
		chk("st_byte_en", 16'hFFFF, st_byte_en);
		for (int i = 0; i < 16; i++) begin
			chk("st_byte", cur[8*i +: 8], st_bytes[i]);
		end
	endtask
	task automatic t_ext();
		@(posedge clk_sys);
		long_mode <= 1'b1;
		req(5'h10, 1'b1, S128, 1'b0, ~cur);
		chk("rd_a", ~cur, rd_a_data);
		@(posedge clk_sys);
		long_mode <= 1'b0;
		rd_b_prefix_ext <= 1'b1;
		#1;
		chk("rd_b", cur, rd_b_data);
	endtask
	task automatic t_csr();
		req(5'h02, 1'b0, S128, 1'b0, 128'h0);
		chk("csr", 32'h0000_1F80, csr_store_data);
		ld(32'h0001_0000);
		chk("fault", 1'b1, general_protection_fault);
		chk("masks", 6'h3F, exc_masks);
		ld(32'h0000_FFC0);
		chk("modes", 2'h3, {flush_active, denormal_input_zero_enable});
		chk("flush_en", 1'b1, flush_underflow_enable);
		for (int r = 0; r < 4; r++) begin
			ld(32'h0000_1F80 | (r << 13));
			chk("round", r, rounding_select);
		end
	endtask
	task automatic t_flags();
		ld(32'h0000_1F80);
		rep(7'h08);
		rep(7'h01);
		chk("flags", 6'h09, exc_flags);
		ld(32'h0000_1F09);
		chk("raise", 1'b0, exc_raise);
		rep(7'h01);
		chk("raise", 1'b1, exc_raise);
	endtask
	task automatic t_modes();
		ld(32'h0000_9F80);
		rep(7'h40);
		chk("flags", 6'h30, exc_flags);
		ld(32'h0000_97C0);
		rep(7'h42);
		chk("flags", 6'h00, exc_flags);
		chk("raise", 1'b0, exc_raise);
	endtask
	initial begin
		{long_mode, rd_a_prefix_ext, rd_b_prefix_ext, wr_en, wr_prefix_ext, wr_scalar, st_en, st_prefix_ext} = '0;
		{csr_load, csr_store, go, unf, det, wr_data, csr_load_data} = '0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		t_csr();
		t_data();
		t_ext();
		t_flags();
		t_modes();
		report_and_stop();
	end
endmodule
